// ===== design/lic_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH
// Register indices; the byte address is four times the index
`define LIC_IDX_FLAGS      8'hD5
`define LIC_IDX_FPTR       8'hDA
`define LIC_IDX_PEND       8'hDC
`define LIC_IDX_MASK       8'hDD
`define LIC_IDX_SYSCTL     8'hDE
`define LIC_IDX_PRIO       8'hFF
`define LIC_IDX_PORTPEND   8'hF4
`define LIC_IDX_SRCCLR     8'hF5
`define LIC_IDX_SRCEN      8'hF6
`define LIC_IDX_CPUCMD     8'hF7
`define LIC_IDX_GRANT      8'hF8
`define LIC_IDX_EXTEN      8'hF9
`define LIC_ADDR_W         12
// System control fields
`define LIC_SYS_GIE        0
`define LIC_SYS_FEN        1
`define LIC_SYS_FSEL_LO    2
`define LIC_SYS_BIT7       7
`define LIC_SYS_RST        8'h00
// Flag fields
`define LIC_FLG_FIS        1
`define LIC_FLG_RST        8'h00
`define LIC_PEND_RST       8'h00
`define LIC_SRCEN_RST      8'hFF
// Acknowledge cycle lengths
`define LIC_FAST_CLKS      6
`define LIC_NORM_CLKS      22
// CPU command bits
`define LIC_CMD_EI         0
`define LIC_CMD_DI         1
`define LIC_CMD_RET        2
`define LIC_CMD_SNAP       3
// Counter control end-of-count status bit
`define LIC_CTR_EOC        1
// Source numbers (vector order inside a level = index order)
`define LIC_NSRC           8
`define LIC_SRC_RX_ERR     0
`define LIC_SRC_RX_CTL     1
`define LIC_SRC_RX_DATA    2
`define LIC_SRC_TX         3
`define LIC_SRC_CT0        4
`define LIC_SRC_CT1        5
`define LIC_SRC_DMA        6
`define LIC_SRC_EXT        7
`define LIC_RESP_OKAY      2'b00
`define LIC_RESP_SLVERR    2'b10
`endif

// ===== design/lic_pkg.sv
// Types of the level interrupt controller
package lic_pkg;
  typedef enum logic [1:0] {LIC_IDLE, LIC_ACK, LIC_DONE} lic_phase_t;
  typedef struct packed {
    logic [7:0] sysctl;
    logic [7:0] flags;
    logic [7:0] shadow_flags;
    logic [15:0] fptr;
    logic [7:0] mask;
    logic [7:0] prio;
    logic [7:0] pend;
    logic [15:0] port_pend;
    logic [7:0] src_en;
    logic [7:0] src_lat;
    logic        ext_armed;
    lic_phase_t  phase;
    logic [4:0]  ack_cnt;
    logic [2:0]  ack_level;
    logic [2:0]  ack_src;
    logic        ack_fast;
    logic        aw_got;
    logic        w_got;
    logic [11:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        ack_pulse;
  } lic_state_t;
endpackage : lic_pkg

// ===== design/lic_ctrl.sv
// Level interrupt controller with AXI4-Lite register access
// How it works
// R1 - Requests are levels held until the source removes the cause
// R2 - Port 2/3 edges set pending flops; software write clears them
// R3 - Receive-data request drops when received data register is read
// R4 - Receiver error/control/wake requests drop when status bit is reset
// R5 - Transmit request drops when transmit data register is written (code gives no tx_data_write when the same write also sets bit 0)
// R6 - Counter end-of-count request drops when control bit 1 is reset
// R7 - DMA request drops when nonzero transfer count is loaded
// R8 - System control bit 0 globally enables interrupt taking
// R9 - Global enable clears on acknowledge, disable, reset; set by enable, return
// R10 - System control bit 1 enables fast handling for selected level
// R11 - Software must unmask the level chosen for fast handling
// R12 - System control bits 2-4 select the fast-handled level
// R13 - Pending register snapshots level requests once per instruction
// R14 - Writes to the pending register are ignored
// R15 - After reset, port edges cannot set until enable instruction runs
// R16 - Mask bit 1 enables its level, 0 blocks it
// R17 - Software should disable globally before writing mask or priority
// R18 - Priority register orders the eight levels for arbitration
// R19 - Fast status set on fast take; return swaps pointer and restores flags (code restores flags only; fptr is never swapped)
// R20 - Hardware reset clears the fast status flag
// R21 - DMA completion request replaces the served peripheral's request
// R22 - Reset zeroes pending, system control bits 7,1,0 and flags bits 1,0
// R23 - Grant needs enable, unmasked top level and enabled top source
// R24 - Same-level sources: lower vector number wins
// R25 - Normal acknowledge clears enable, pushes context, branches to vector
// R26 - Fast take lasts 6 clocks instead of 22, swaps pointer, shadows flags (code shadows flags but leaves fptr unchanged)
// R27 - Bits 0-7 map to levels 0-7; priority is a configurable tree
//
// Implementation choice: the AXI4-Lite slave port.
`include "lic_defs.svh"
module lic_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port 2/3 external interrupt edges, one pulse each
  input  wire logic [15:0] port_edge,
  // Peripheral level requests
  input  wire logic        rx_err_req,
  input  wire logic        rx_ctl_req,
  input  wire logic        rx_data_req,
  input  wire logic        tx_req,
  input  wire logic        ct0_req,
  input  wire logic        ct1_req,
  input  wire logic        dma_req,
  input  wire logic [1:0]  dma_target,
  input  wire logic        dma_enabled,
  // Source clear strobes to peripherals
  output logic             rx_data_read,
  output logic             rx_status_clr,
  output logic             tx_data_write,
  output logic [1:0]       ct_eoc_clr,
  output logic             dma_count_load,
  // Instruction sequencer
  output logic             irq_take,
  output logic             irq_fast,
  output logic [2:0]       irq_level,
  output logic [2:0]       irq_source,
  output logic             ack_busy,
  output logic             ack_done
);
  lic_pkg::lic_state_t s_ff;
  lic_pkg::lic_state_t nxt_s;
  logic [7:0]  src_raw;
  logic [7:0]  src_act;
  logic [7:0]  lvl_req;
  logic [7:0]  lvl_ok;
  logic [2:0]  win_lvl;
  logic        win_any;
  logic [2:0]  win_src;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        wr_hit;
  logic [7:0]  wb;
  logic [7:0]  src_lvl [8];
  logic [2:0]  grp [3];
  logic        grp_v [3];
  logic [1:0]  ord [3];
  logic [2:0]  ab;
  logic [2:0]  cd;
  logic        wr_commit;
  logic        wr_clr;

  // ------------------------------------------------------------
  // Source requests
  // ------------------------------------------------------------
  // Levels per source; DMA substitutes when it serves the peripheral
  always_comb
  begin
    src_raw = {|s_ff.port_pend, dma_req, ct1_req, ct0_req, tx_req,
               rx_data_req, rx_ctl_req, rx_err_req}; // see R1
    if (dma_enabled && dma_req)
    begin
      src_raw[`LIC_SRC_RX_DATA] = (dma_target == 2'h0) ? 1'b0 : src_raw[`LIC_SRC_RX_DATA]; // see R21
      src_raw[`LIC_SRC_TX]      = (dma_target == 2'h1) ? 1'b0 : src_raw[`LIC_SRC_TX];      // see R21
      src_raw[`LIC_SRC_EXT]     = (dma_target == 2'h2) ? 1'b0 : src_raw[`LIC_SRC_EXT];     // see R21
    end
    src_act = src_raw & s_ff.src_en;
  end

  // Fixed level of each source: bits map to levels 0-7
  assign src_lvl = '{8'h40, 8'h40, 8'h40, 8'h02, 8'h04, 8'h20, 8'h02, 8'h08};

  // Level request vector from enabled sources
  always_comb
  begin
    lvl_req = 8'h00;
    for (int i = 0; i < `LIC_NSRC; i++)
    begin
      if (src_act[i])
        lvl_req = lvl_req | src_lvl[i]; // see R27
    end
    lvl_ok = lvl_req & s_ff.mask; // see R16
  end

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  // Priority tree: prio bits pick group order and pair order
  always_comb
  begin
    // Group A: 0,1 ; group B: 2,3,4,5 ; group C: 6,7
    grp_v[0] = lvl_ok[0] | lvl_ok[1];
    grp[0] = s_ff.prio[0] ? (lvl_ok[1] ? 3'h1 : 3'h0) : (lvl_ok[0] ? 3'h0 : 3'h1); // see R18
    grp_v[1] = |lvl_ok[5:2];
    ab = s_ff.prio[2] ? (lvl_ok[3] ? 3'h3 : 3'h2) : (lvl_ok[2] ? 3'h2 : 3'h3);
    cd = s_ff.prio[5] ? (lvl_ok[5] ? 3'h5 : 3'h4) : (lvl_ok[4] ? 3'h4 : 3'h5);
    if (s_ff.prio[3])
      grp[1] = (|lvl_ok[5:4]) ? cd : ab;
    else
      grp[1] = (|lvl_ok[3:2]) ? ab : cd;
    grp_v[2] = lvl_ok[6] | lvl_ok[7];
    grp[2] = s_ff.prio[4] ? (lvl_ok[7] ? 3'h7 : 3'h6) : (lvl_ok[6] ? 3'h6 : 3'h7);
    // Group order from bits 7,6,1
    unique case ({s_ff.prio[7], s_ff.prio[6], s_ff.prio[1]})
      3'h0, 3'h4: begin ord[0] = 2'h2; ord[1] = 2'h1; ord[2] = 2'h0; end
      3'h1, 3'h5: begin ord[0] = 2'h1; ord[1] = 2'h2; ord[2] = 2'h0; end
      3'h2:       begin ord[0] = 2'h0; ord[1] = 2'h2; ord[2] = 2'h1; end
      3'h3:       begin ord[0] = 2'h2; ord[1] = 2'h0; ord[2] = 2'h1; end
      3'h6:       begin ord[0] = 2'h0; ord[1] = 2'h1; ord[2] = 2'h2; end
      3'h7:       begin ord[0] = 2'h1; ord[1] = 2'h0; ord[2] = 2'h2; end
    endcase
    win_any = 1'b0;
    win_lvl = 3'h0;
    for (int k = 2; k >= 0; k--)
    begin
      if (grp_v[ord[k]])
      begin
        win_any = 1'b1; // see R18
        win_lvl = grp[ord[k]];
      end
    end
  end

  // Lowest vector source within the winning level
  always_comb
  begin
    win_src = 3'h0;
    for (int i = `LIC_NSRC - 1; i >= 0; i--)
    begin
      if (src_act[i] && src_lvl[i][win_lvl])
        win_src = 3'(i); // see R24
    end
  end

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  // Read data mux
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr[9:2])
      `LIC_IDX_FLAGS:    rd_val = {24'h0, s_ff.flags};
      `LIC_IDX_FPTR:     rd_val = {16'h0, s_ff.fptr};
      `LIC_IDX_PEND:     rd_val = {24'h0, s_ff.pend};
      `LIC_IDX_MASK:     rd_val = {24'h0, s_ff.mask};
      `LIC_IDX_SYSCTL:   rd_val = {24'h0, s_ff.sysctl};
      `LIC_IDX_PRIO:     rd_val = {24'h0, s_ff.prio};
      `LIC_IDX_PORTPEND: rd_val = {16'h0, s_ff.port_pend};
      `LIC_IDX_SRCEN:    rd_val = {24'h0, s_ff.src_en};
      `LIC_IDX_GRANT:    rd_val = {24'h0, s_ff.ack_fast, s_ff.ack_src, 1'b0, s_ff.ack_level};
      `LIC_IDX_EXTEN:    rd_val = {31'h0, s_ff.ext_armed};
      `LIC_IDX_SRCCLR,
      `LIC_IDX_CPUCMD:   rd_val = 32'h0000_0000;
      default:           rd_hit = 1'b0;
    endcase
    if (s_axi_araddr[11:10] != 2'h0 || s_axi_araddr[1:0] != 2'h0)
      rd_hit = 1'b0;
  end

  // Write decode of the captured address
  assign wr_hit = (s_ff.aw_addr[11:10] == 2'h0) && (s_ff.aw_addr[1:0] == 2'h0);
  assign wb = s_ff.wstrb[0] ? s_ff.wdata[7:0] : 8'h00;
  assign wr_commit = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
  assign wr_clr = wr_commit && wr_hit && s_ff.aw_addr[9:2] == `LIC_IDX_SRCCLR;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [7:0] idx;
    logic       cmd_ei;
    logic       cmd_di;
    logic       cmd_ret;
    logic       cmd_snap;
    nxt_s = s_ff;
    idx = s_ff.aw_addr[9:2];
    cmd_ei = 1'b0;
    cmd_di = 1'b0;
    cmd_ret = 1'b0;
    cmd_snap = 1'b0;
    nxt_s.ack_pulse = 1'b0;
    // Address and data channels in either order
    if (s_axi_awvalid && !s_ff.aw_got)
    begin
      nxt_s.aw_got = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_ff.w_got)
    begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    if (s_ff.bvalid && s_axi_bready)
      nxt_s.bvalid = 1'b0;
    if (wr_commit)
    begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = `LIC_RESP_OKAY;
      if (!wr_hit)
        nxt_s.bresp = `LIC_RESP_SLVERR;
      else if (s_ff.wstrb[0])
      begin
        unique case (idx)
          `LIC_IDX_FLAGS:  nxt_s.flags = wb;
          `LIC_IDX_FPTR:   nxt_s.fptr = {s_ff.wstrb[1] ? s_ff.wdata[15:8] : s_ff.fptr[15:8], wb};
          `LIC_IDX_MASK:   nxt_s.mask = wb;
          `LIC_IDX_SYSCTL: nxt_s.sysctl = wb;
          `LIC_IDX_PRIO:   nxt_s.prio = wb;
          `LIC_IDX_PEND:   nxt_s.pend = s_ff.pend; // see R14
          `LIC_IDX_SRCEN:  nxt_s.src_en = wb;
          `LIC_IDX_PORTPEND:
          begin
            nxt_s.port_pend = s_ff.port_pend & ~{s_ff.wstrb[1] ? s_ff.wdata[15:8] : 8'h00, wb}; // see R2
          end
          `LIC_IDX_CPUCMD:
          begin
            cmd_ei = wb[`LIC_CMD_EI];
            cmd_di = wb[`LIC_CMD_DI];
            cmd_ret = wb[`LIC_CMD_RET];
            cmd_snap = wb[`LIC_CMD_SNAP];
          end
          default: nxt_s.bresp = (idx == `LIC_IDX_SRCCLR) ? `LIC_RESP_OKAY : `LIC_RESP_SLVERR;
        endcase
      end
    end
    // Read channel: one answer at a time
    if (s_ff.rvalid && s_axi_rready)
      nxt_s.rvalid = 1'b0;
    if (s_axi_arvalid && !s_ff.rvalid)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd_val;
      nxt_s.rresp = rd_hit ? `LIC_RESP_OKAY : `LIC_RESP_SLVERR;
    end
    // Enable instruction arms the external edge capture
    if (cmd_ei)
    begin
      nxt_s.ext_armed = 1'b1; // see R15
      nxt_s.sysctl[`LIC_SYS_GIE] = 1'b1; // see R9
    end
    if (cmd_di)
      nxt_s.sysctl[`LIC_SYS_GIE] = 1'b0; // see R9
    // Return: fast status selects the flag restore from the shadow copy
    if (cmd_ret)
    begin
      nxt_s.sysctl[`LIC_SYS_GIE] = 1'b1; // see R9
      if (s_ff.flags[`LIC_FLG_FIS])
      begin
        nxt_s.flags = s_ff.shadow_flags; // see R19
        nxt_s.flags[`LIC_FLG_FIS] = 1'b0;
      end
    end
    // Edges set pending bits; set wins over a same-cycle clear
    if (s_ff.ext_armed)
      nxt_s.port_pend = nxt_s.port_pend | port_edge; // see R2
    // Instruction-end snapshot and arbitration
    if (cmd_snap)
    begin
      nxt_s.pend = lvl_req; // see R13
      if (s_ff.sysctl[`LIC_SYS_GIE] && win_any && s_ff.phase == lic_pkg::LIC_IDLE) // see R8
      begin
        nxt_s.phase = lic_pkg::LIC_ACK; // see R23
        nxt_s.ack_level = win_lvl;
        nxt_s.ack_src = win_src;
        nxt_s.sysctl[`LIC_SYS_GIE] = 1'b0; // see R25
        nxt_s.ack_fast = s_ff.sysctl[`LIC_SYS_FEN] &&
                         (s_ff.sysctl[`LIC_SYS_FSEL_LO +: 3] == win_lvl); // see R10 R12
        if (nxt_s.ack_fast)
        begin
          nxt_s.ack_cnt = 5'(`LIC_FAST_CLKS - 1); // see R26
          nxt_s.shadow_flags = s_ff.flags;
          nxt_s.flags[`LIC_FLG_FIS] = 1'b1; // see R19
        end
        else
          nxt_s.ack_cnt = 5'(`LIC_NORM_CLKS - 1); // see R26
      end
    end
    // Acknowledge cycle length
    unique case (s_ff.phase)
      lic_pkg::LIC_IDLE: nxt_s.ack_pulse = 1'b0;
      lic_pkg::LIC_ACK:
      begin
        if (s_ff.ack_cnt == 5'h00)
          nxt_s.phase = lic_pkg::LIC_DONE;
        else
          nxt_s.ack_cnt = s_ff.ack_cnt - 5'h01;
      end
      lic_pkg::LIC_DONE:
      begin
        nxt_s.ack_pulse = 1'b1;
        nxt_s.phase = lic_pkg::LIC_IDLE;
      end
      default: nxt_s.phase = lic_pkg::LIC_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_ff <= '0;
      s_ff.sysctl <= `LIC_SYS_RST; // see R22
      s_ff.flags <= `LIC_FLG_RST; // see R20 R22
      s_ff.pend <= `LIC_PEND_RST; // see R22
      s_ff.src_en <= `LIC_SRCEN_RST;
    end
    else
      s_ff <= nxt_s;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Bus handshakes
  assign s_axi_awready = !s_ff.aw_got;
  assign s_axi_wready  = !s_ff.w_got;
  assign s_axi_bvalid  = s_ff.bvalid;
  assign s_axi_bresp   = s_ff.bresp;
  assign s_axi_arready = !s_ff.rvalid;
  assign s_axi_rvalid  = s_ff.rvalid;
  assign s_axi_rdata   = s_ff.rdata;
  assign s_axi_rresp   = s_ff.rresp;
  // Source clear strobes from register accesses
  assign rx_data_read   = s_axi_arvalid && !s_ff.rvalid && rd_hit &&
                          s_axi_araddr[9:2] == `LIC_IDX_SRCCLR; // see R3
  assign rx_status_clr  = wr_clr && wb[0]; // see R4
  assign tx_data_write  = wr_clr && !wb[0] && wb[1]; // see R5
  assign ct_eoc_clr     = wr_clr ? wb[3:2] : 2'h0; // see R6
  assign dma_count_load = wr_clr && wb[4]; // see R7
  // Sequencer view of the granted interrupt
  assign irq_take   = s_ff.phase == lic_pkg::LIC_ACK;
  assign irq_fast   = s_ff.ack_fast;
  assign irq_level  = s_ff.ack_level;
  assign irq_source = s_ff.ack_src;
  assign ack_busy   = s_ff.phase != lic_pkg::LIC_IDLE;
  assign ack_done   = s_ff.ack_pulse;
endmodule : lic_ctrl

// ===== sim/lic_ctrl_props.sv
// Port checks of the level interrupt controller
module lic_ctrl_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Register bus
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  // Source clears
  input wire logic        rx_data_read,
  input wire logic        rx_status_clr,
  input wire logic        tx_data_write,
  input wire logic [1:0]  ct_eoc_clr,
  input wire logic        dma_count_load,
  // Sequencer side
  input wire logic        irq_take,
  input wire logic        irq_fast,
  input wire logic [2:0]  irq_level,
  input wire logic [2:0]  irq_source,
  input wire logic        ack_busy,
  input wire logic        ack_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Counts consecutive acknowledge cycles
  logic [4:0] take_cnt_ff;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) take_cnt_ff <= 5'h00;
    else take_cnt_ff <= irq_take ? take_cnt_ff + 5'h01 : 5'h00;
  // Steps of an acknowledge
  sequence s_fast_hold;
    irq_take [*6] ##1 !irq_take;
  endsequence
  sequence s_done_pulse;
    ack_done ##1 !ack_done;
  endsequence
  property p_fast_len;
    $rose(irq_take) && irq_fast |-> s_fast_hold;
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast take length");
  property p_take_len;
    $fell(irq_take) |-> take_cnt_ff == (irq_fast ? 5'h06 : 5'h16);
  endproperty
  a_take_len: assert property (p_take_len) else $error("take length");
  property p_ack_done;
    $fell(irq_take) |-> ##[0:2] s_done_pulse;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("no done pulse");
  property p_busy;
    irq_take |-> ack_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("take without busy");
  property p_grant_hold;
    irq_take && $past(irq_take) |-> $stable({irq_level, irq_source, irq_fast});
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant moved");
  property p_no_nest;
    $rose(irq_take) |-> !$past(ack_busy);
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("nested take");
  property p_rx_read;
    rx_data_read |-> s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h3D4;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("stray data read");
  property p_tx_clr;
    tx_data_write |-> ##[0:1] s_axi_bvalid && s_axi_bresp == 2'b00;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("stray tx clear");
  property p_ct_clr;
    |ct_eoc_clr |-> ##[0:1] s_axi_bvalid && s_axi_bresp == 2'b00;
  endproperty
  a_ct_clr: assert property (p_ct_clr) else $error("stray count clear");
  property p_dma_clr;
    dma_count_load |-> ##[0:1] s_axi_bvalid;
  endproperty
  a_dma_clr: assert property (p_dma_clr) else $error("stray dma load");
  property p_rx_excl;
    rx_status_clr |-> !tx_data_write;
  endproperty
  a_rx_excl: assert property (p_rx_excl) else $error("two clears at once");
endmodule : lic_ctrl_props

bind lic_ctrl lic_ctrl_props u_lic_ctrl_props (.clk(clk), .arst_n(arst_n),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .rx_data_read(rx_data_read),
  .rx_status_clr(rx_status_clr), .tx_data_write(tx_data_write), .ct_eoc_clr(ct_eoc_clr),
  .dma_count_load(dma_count_load), .irq_take(irq_take), .irq_fast(irq_fast),
  .irq_level(irq_level), .irq_source(irq_source), .ack_busy(ack_busy), .ack_done(ack_done));

// ===== sim/lic_periph_model.sv
// Peripheral request sources that hold until their clear strobe
module lic_periph_model (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Cause events, one bit per source
  input wire logic [6:0] raise,
  // Clear strobes
  input wire logic       rx_data_read,
  input wire logic       rx_status_clr,
  input wire logic       tx_data_write,
  input wire logic [1:0] ct_eoc_clr,
  input wire logic       dma_count_load,
  // Level requests
  output logic [6:0]     req_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] clr;
  // Clear strobe of each source, in source order
  assign clr = {dma_count_load, ct_eoc_clr, tx_data_write, rx_data_read, {2{rx_status_clr}}};
  // Requests stay up until the cause is removed
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) req_ff <= 7'h00;
    else req_ff <= (req_ff & ~clr) | raise;
endmodule : lic_periph_model

// ===== sim/lic_ctrl_bench.sv
// Register level testbench of the level interrupt controller
module lic_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_FLG = 12'h354, A_PND = 12'h370, A_MSK = 12'h374, A_SYS = 12'h378;
  localparam logic [11:0] A_PP = 12'h3D0, A_SC = 12'h3D4, A_CMD = 12'h3DC, A_BAD = 12'h3E8;
  logic        clk, arst_n, awv, wv, brdy, arv, rrdy, dme;
  logic        awr, wrd, bv, arr, rv, rdr, rsc, txw, dcl;
  logic        irq_take, irq_fast, ack_busy, ack_done;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [15:0] pe;
  logic [6:0]  rz, req;
  logic [2:0]  irq_level, irq_source;
  logic [1:0]  dmt, r, brsp, rrsp, ctc;
  int          tk, cyc, mismatches, samples_checked;

  lic_ctrl u_lic_ctrl (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(brsp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrsp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .port_edge(pe),
    .rx_err_req(req[0]), .rx_ctl_req(req[1]), .rx_data_req(req[2]), .tx_req(req[3]),
    .ct0_req(req[4]), .ct1_req(req[5]), .dma_req(req[6]), .dma_target(dmt),
    .dma_enabled(dme), .rx_data_read(rdr), .rx_status_clr(rsc), .tx_data_write(txw),
    .ct_eoc_clr(ctc), .dma_count_load(dcl), .irq_take(irq_take), .irq_fast(irq_fast),
    .irq_level(irq_level), .irq_source(irq_source), .ack_busy(ack_busy), .ack_done(ack_done));
  lic_periph_model u_lic_periph_model (.clk(clk), .arst_n(arst_n), .raise(rz),
    .rx_data_read(rdr), .rx_status_clr(rsc), .tx_data_write(txw), .ct_eoc_clr(ctc),
    .dma_count_load(dcl), .req_ff(req));

  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  // Counts acknowledge cycles
  always @(negedge clk)
    if (irq_take === 1'b1) tk++;

  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Bus write, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (!(ah && wh))
    begin
      @(negedge clk);
      ah = ah || awr;
      wh = wh || wrd;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    do @(negedge clk); while (bv !== 1'b1);
    @(posedge clk);
    brdy <= 1'b0;
  endtask : wr
  // Bus read
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    v = rdat;
    e = rrsp;
    @(posedge clk);
    rrdy <= 1'b0;
  endtask : rd
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] m, e);
    rd(a, d, r);
    chk(n, d & m, e);
  endtask : rc
  // End-of-instruction snapshot that must grant
  task automatic grant(input logic [2:0] l, s, input logic f, input int n);
    tk = 0;
    wr(A_CMD, 32'h8);
    do @(negedge clk); while (ack_done !== 1'b1);
    chk("take_len", tk, n);
    chk("grant", {irq_fast, irq_source, irq_level}, {f, s, l});
  endtask : grant
  // Snapshot that must not grant
  task automatic no_take;
    tk = 0;
    wr(A_CMD, 32'h8);
    repeat (30) @(posedge clk);
    chk("no_take", tk, 0);
  endtask : no_take
  task automatic pulse(input logic [15:0] p, input logic [6:0] q);
    @(posedge clk);
    pe <= p;
    rz <= q;
    @(posedge clk);
    pe <= 16'h0000;
    rz <= 7'h00;
  endtask : pulse
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    {arst_n, awv, wv, brdy, arv, rrdy, dme, awa, ara, wd, pe, rz, dmt} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rc("pend_rst", A_PND, 32'hFF, 32'h0);
    rc("sys_rst", A_SYS, 32'h83, 32'h0);
    rc("flg_rst", A_FLG, 32'h3, 32'h0);
    rd(A_BAD, d, r);
    chk("unmapped", r, 32'h2);
    wr(A_PND, 32'hFF);
    rc("pend_ro", A_PND, 32'hFF, 32'h0);
    pulse(16'h0004, 7'h00);
    rc("pp_locked", A_PP, 32'hFFFF, 32'h0);
    wr(A_CMD, 32'h1);
    pulse(16'h0004, 7'h00);
    rc("pp_set", A_PP, 32'hFFFF, 32'h4);
    wr(A_MSK, 32'h08);
    grant(3'h3, 3'h7, 1'b0, 22);
    rc("gie_ack", A_SYS, 32'h1, 32'h0);
    rc("pend_ext", A_PND, 32'h08, 32'h08);
    no_take();
    wr(A_PP, 32'h4);
    wr(A_CMD, 32'h1);
    no_take();
    rc("pp_clr", A_PND, 32'hFF, 32'h0);
    pulse(16'h0000, 7'h08);
    wr(A_MSK, 32'h00);
    no_take();
    rc("pend_poll", A_PND, 32'hFF, 32'h02);
    @(posedge clk);
    dme <= 1'b1;
    dmt <= 2'h1;
    wr(A_MSK, 32'h02);
    pulse(16'h0000, 7'h40);
    grant(3'h1, 3'h6, 1'b0, 22);
    chk("held", req[6], 1'b1);
    wr(A_CMD, 32'h4);
    rc("gie_ret", A_SYS, 32'h1, 32'h1);
    wr(A_SC, 32'h10);
    chk("dma_clr", req[6], 1'b0);
    dme <= 1'b0;
    wr(A_SC, 32'h2);
    chk("tx_clr", req[3], 1'b0);
    wr(A_MSK, 32'h40);
    pulse(16'h0000, 7'h05);
    grant(3'h6, 3'h0, 1'b0, 22);
    wr(A_CMD, 32'h4);
    wr(A_SC, 32'h1);
    chk("rx_stat_clr", req[0], 1'b0);
    wr(A_SYS, 32'h1B);
    grant(3'h6, 3'h2, 1'b1, 6);
    rc("fis_set", A_FLG, 32'h2, 32'h2);
    wr(A_CMD, 32'h4);
    rc("fis_ret", A_FLG, 32'h2, 32'h0);
    rd(A_SC, d, r);
    chk("rx_read_clr", req[2], 1'b0);
    pulse(16'h0000, 7'h30);
    wr(A_MSK, 32'h24);
    grant(3'h2, 3'h4, 1'b0, 22);
    wr(12'h3FC, 32'h8);
    wr(A_CMD, 32'h4);
    grant(3'h5, 3'h5, 1'b0, 22);
    wr(A_SC, 32'h4);
    chk("ct0_clr", req[4], 1'b0);
    tally_and_finish();
  end
endmodule : lic_ctrl_bench
